// *** adc_channel_select_and_results.sv ***
// Overview of operation
// - First disable register: seven channel-off bits
// - Second disable register: four channel-off bits
// - Disable bits clear on reset and command
// - Input current signed, bus to mid-node positive
// - Input current one milliampere per bit
// - Battery current signed, charging positive
// - Battery current one milliampere per bit
// - Bus and input voltage one millivolt per bit
// - Results read-only, zero after power-on
// - No conversion without master enable bit
// - Continuous or one-shot scan by rate bit
`timescale 1ns/1ps
`default_nettype none
module adc_channel_select_and_results #(
   parameter logic [6:0] DEV_ADDR = 7'h40 // Arbitrary bus address
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic sclPin,
   input wire logic sdaPin,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic regResetCmd,
   input wire logic watchdogExpiry,
   output logic convStart,
   output logic [3:0] convChannel,
   input wire logic convDone,
   input wire logic [15:0] convData
);

   // ********************************************************
   // Pin synchronisers and bus condition detect
   // ********************************************************
   logic [1:0] pinSync;
   logic sclPrev, sdaPrev;
   logic sclNow, sdaNow;
   logic startSeen, stopSeen, sclRise, sclFall;

   pin_sync #(.WIDTH(2)) u_pin_sync (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .d({sclPin, sdaPin}),
      .q(pinSync)
   );

   // Edge and start/stop decode on synchronised levels
   always_comb begin
      sclNow = pinSync[1];
      sdaNow = pinSync[0];
      startSeen = sclNow && sclPrev && sdaPrev && !sdaNow;
      stopSeen = sclNow && sclPrev && !sdaPrev && sdaNow;
      sclRise = sclNow && !sclPrev;
      sclFall = !sclNow && sclPrev;
   end

   // ********************************************************
   // Registers
   // ********************************************************
   logic [7:0] ctrl, next_ctrl;
   logic [7:0] disPri, next_disPri;
   logic [7:0] disSec, next_disSec;
   logic [15:0] input_current_result_word, next_ibus;
   logic [15:0] battery_current_result_word, next_ibat;
   logic [15:0] bus_voltage_result_word, next_vbus;
   logic [15:0] first_input_result_word, next_vac1;
   logic [7:0] rdByte;

   scan_if scan ();

   // Read decode of the register map
   function automatic logic [7:0] readByte(input logic [7:0] a);
      logic [7:0] r;
      r = adc_regs_pkg::READ_UNMAPPED;
      case (a)
         adc_regs_pkg::ADDR_CTRL: r = ctrl;
         adc_regs_pkg::ADDR_DIS_PRI: r = disPri;
         adc_regs_pkg::ADDR_DIS_SEC: r = disSec;
         adc_regs_pkg::ADDR_IBUS_HI: r = input_current_result_word[15:8];
         adc_regs_pkg::ADDR_IBUS_LO: r = input_current_result_word[7:0];
         adc_regs_pkg::ADDR_IBAT_HI: r = battery_current_result_word[15:8];
         adc_regs_pkg::ADDR_IBAT_LO: r = battery_current_result_word[7:0];
         adc_regs_pkg::ADDR_VBUS_HI: r = bus_voltage_result_word[15:8];
         adc_regs_pkg::ADDR_VBUS_LO: r = bus_voltage_result_word[7:0];
         adc_regs_pkg::ADDR_VAC1_HI: r = first_input_result_word[15:8];
         adc_regs_pkg::ADDR_VAC1_LO: r = first_input_result_word[7:0];
         default: r = adc_regs_pkg::READ_UNMAPPED;
      endcase
      return r;
   endfunction

   // ********************************************************
   // Serial target state machine
   // ********************************************************
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_ADDR = 4'h1,
      S_ACK_ADDR = 4'h2,
      S_PTR = 4'h3,
      S_ACK_PTR = 4'h4,
      S_WDATA = 4'h5,
      S_ACK_WDATA = 4'h6,
      S_RDATA = 4'h7,
      S_ACK_RDATA = 4'h8
   } bus_e;

   bus_e state, next_state;
   logic [7:0] shift, next_shift;
   logic [3:0] bitCnt, next_bitCnt;
   logic [7:0] ptr, next_ptr;
   logic rw, next_rw;
   logic next_sdaOe;
   logic wrEn, next_wrEn;
   logic byteDone;

   // Byte read back for the current pointer
   always_comb begin
      rdByte = readByte(ptr);
   end

   // Next bus state on each condition or clock edge
   always_comb begin
      next_state = state;
      next_shift = shift;
      next_bitCnt = bitCnt;
      next_ptr = ptr;
      next_rw = rw;
      next_sdaOe = sdaOe;
      next_wrEn = 1'b0;
      byteDone = sclFall && (bitCnt == adc_regs_pkg::BITS_PER_BYTE);
      if (startSeen) begin
         next_state = S_ADDR;
         next_bitCnt = adc_regs_pkg::BIT_ZERO;
         next_sdaOe = 1'b0;
      end else if (stopSeen) begin
         next_state = S_IDLE;
         next_sdaOe = 1'b0;
      end else begin
         case (state)
            S_ADDR, S_PTR, S_WDATA: begin
               if (sclRise) begin
                  next_shift = {shift[6:0], sdaNow};
                  next_bitCnt = bitCnt + adc_regs_pkg::BIT_ONE;
               end else if (byteDone) begin
                  next_sdaOe = 1'b1;
                  if (state == S_ADDR) begin
                     if (shift[7:1] == DEV_ADDR) begin
                        next_rw = shift[0];
                        next_state = S_ACK_ADDR;
                     end else begin
                        next_sdaOe = 1'b0;
                        next_state = S_IDLE;
                     end
                  end else if (state == S_PTR) begin
                     next_ptr = shift;
                     next_state = S_ACK_PTR;
                  end else begin
                     next_wrEn = 1'b1;
                     next_state = S_ACK_WDATA;
                  end
               end
            end
            S_ACK_ADDR: begin
               if (sclFall) begin
                  if (rw) begin
                     next_shift = rdByte;
                     next_sdaOe = !rdByte[7];
                     next_bitCnt = adc_regs_pkg::BIT_ONE;
                     next_state = S_RDATA;
                  end else begin
                     next_sdaOe = 1'b0;
                     next_bitCnt = adc_regs_pkg::BIT_ZERO;
                     next_state = S_PTR;
                  end
               end
            end
            S_ACK_PTR, S_ACK_WDATA: begin
               if (sclFall) begin
                  next_sdaOe = 1'b0;
                  next_bitCnt = adc_regs_pkg::BIT_ZERO;
                  next_state = S_WDATA;
                  if (state == S_ACK_WDATA) begin
                     next_ptr = ptr + adc_regs_pkg::PTR_STEP;
                  end
               end
            end
            S_RDATA: begin
               if (byteDone) begin
                  next_sdaOe = 1'b0;
                  next_state = S_ACK_RDATA;
               end else if (sclFall) begin
                  next_shift = {shift[6:0], 1'b0};
                  next_sdaOe = !shift[6];
                  next_bitCnt = bitCnt + adc_regs_pkg::BIT_ONE;
               end
            end
            S_ACK_RDATA: begin
               if (sclRise) begin
                  if (sdaNow) begin
                     next_state = S_IDLE; // Host ended the read
                  end else begin
                     next_ptr = ptr + adc_regs_pkg::PTR_STEP;
                  end
               end else if (sclFall) begin
                  next_shift = rdByte;
                  next_sdaOe = !rdByte[7];
                  next_bitCnt = adc_regs_pkg::BIT_ONE;
                  next_state = S_RDATA;
               end
            end
            default: begin
               next_state = S_IDLE;
            end
         endcase
      end
   end

   // Bus state registers
   always_ff @(posedge clock) begin
      if (rst) begin
         state <= S_IDLE;
         shift <= 8'h00;
         bitCnt <= adc_regs_pkg::BIT_ZERO;
         ptr <= 8'h00;
         rw <= 1'b0;
         sdaOe <= 1'b0;
         sdaOut <= 1'b0;
         wrEn <= 1'b0;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else if (ce) begin
         state <= next_state;
         shift <= next_shift;
         bitCnt <= next_bitCnt;
         ptr <= next_ptr;
         rw <= next_rw;
         sdaOe <= next_sdaOe;
         sdaOut <= 1'b0; // Open drain: only ever pulls low
         wrEn <= next_wrEn;
         sclPrev <= sclNow;
         sdaPrev <= sdaNow;
      end
   end

   // ********************************************************
   // Register file update
   // ********************************************************
   always_comb begin
      next_ctrl = ctrl;
      next_disPri = disPri;
      next_disSec = disSec;
      next_ibus = input_current_result_word;
      next_ibat = battery_current_result_word;
      next_vbus = bus_voltage_result_word;
      next_vac1 = first_input_result_word;
      if (regResetCmd) begin
         next_ctrl = adc_regs_pkg::CTRL_RESET;
         next_disPri = adc_regs_pkg::DIS_RESET;
         next_disSec = adc_regs_pkg::DIS_RESET;
      end else begin
         if (scan.passDone && ctrl[adc_regs_pkg::CTRL_RATE_BIT]) begin
            next_ctrl[adc_regs_pkg::CTRL_EN_BIT] = 1'b0;
         end
         if (wrEn) begin
            // Result offsets have no write path
            case (ptr)
               adc_regs_pkg::ADDR_CTRL: begin
                  next_ctrl = shift & adc_regs_pkg::CTRL_WMASK;
               end
               adc_regs_pkg::ADDR_DIS_PRI: begin
                  next_disPri = shift & adc_regs_pkg::DIS_PRI_WMASK;
               end
               adc_regs_pkg::ADDR_DIS_SEC: begin
                  next_disSec = shift & adc_regs_pkg::DIS_SEC_WMASK;
               end
               default: begin
                  next_disSec = disSec;
               end
            endcase
         end
         if (watchdogExpiry) begin
            next_ctrl[adc_regs_pkg::CTRL_EN_BIT] = 1'b0;
         end
      end
      // Converter words stored unchanged: signed, unit per bit, no offset
      if (scan.resultValid) begin
         case (scan.resultChan)
            adc_regs_pkg::CH_IBUS: next_ibus = scan.resultWord;
            adc_regs_pkg::CH_IBAT: next_ibat = scan.resultWord;
            adc_regs_pkg::CH_VBUS: next_vbus = scan.resultWord;
            adc_regs_pkg::CH_VAC1: next_vac1 = scan.resultWord;
            default: next_vac1 = first_input_result_word;
         endcase
      end
   end

   // Register state
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl <= adc_regs_pkg::CTRL_RESET;
         disPri <= adc_regs_pkg::DIS_RESET;
         disSec <= adc_regs_pkg::DIS_RESET;
         input_current_result_word <= adc_regs_pkg::RESULT_RESET;
         battery_current_result_word <= adc_regs_pkg::RESULT_RESET;
         bus_voltage_result_word <= adc_regs_pkg::RESULT_RESET;
         first_input_result_word <= adc_regs_pkg::RESULT_RESET;
      end else if (ce) begin
         ctrl <= next_ctrl;
         disPri <= next_disPri;
         disSec <= next_disSec;
         input_current_result_word <= next_ibus;
         battery_current_result_word <= next_ibat;
         bus_voltage_result_word <= next_vbus;
         first_input_result_word <= next_vac1;
      end
   end

   // ********************************************************
   // Scan control
   // ********************************************************
   // Channel-off bits in scan order
   always_comb begin
      scan.enable = ctrl[adc_regs_pkg::CTRL_EN_BIT];
      scan.oneShot = ctrl[adc_regs_pkg::CTRL_RATE_BIT];
      scan.offMask = {disSec[4], disSec[5], disSec[6], disSec[7],
                      disPri[1], disPri[2], disPri[3], disPri[4],
                      disPri[5], disPri[6], disPri[7]};
   end

   adc_scan_seq u_adc_scan_seq (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .scan(scan.seq),
      .convStart(convStart),
      .convChannel(convChannel),
      .convDone(convDone),
      .convData(convData)
   );

endmodule // adc_channel_select_and_results
`default_nettype wire

// *** adc_channel_select_and_results_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_channel_select_and_results_assertions (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic sclPin,
   input wire logic sdaPin,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic regResetCmd,
   input wire logic watchdogExpiry,
   input wire logic convStart,
   input wire logic [3:0] convChannel,
   input wire logic convDone,
   input wire logic [15:0] convData
);
   logic busy;
   logic next_busy;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst || !ce);

   // Outstanding conversion request
   always_comb begin
      next_busy = busy;
      if (convStart) next_busy = 1'h1;
      if (convDone || regResetCmd || watchdogExpiry) next_busy = 1'h0;
   end
   always_ff @(posedge clock) begin
      if (rst) busy <= 1'h0;
      else if (ce) busy <= next_busy;
   end

   // Request pulse, and a quiet spell after an abort
   sequence request;
      convStart ##1 !convStart;
   endsequence
   sequence quiet8;
      (!convStart) [*8];
   endsequence

   reset_quiet_a: assert property (disable iff (1'h0) rst && ce |=>
      !convStart && !sdaOe && !sdaOut && convChannel == 4'h0)
      else $error("outputs active after reset");
   start_pulse_a: assert property (convStart |-> request)
      else $error("request pulse longer than one cycle");
   done_pace_a: assert property (convDone |=> !convStart)
      else $error("request in the cycle after a result");
   one_request_a: assert property (busy |-> !convStart)
      else $error("second request while one is open");
   chan_range_a: assert property (convStart |-> convChannel <= 4'ha)
      else $error("request for a channel that does not exist");
   chan_stable_a: assert property (busy && !convDone |=>
      $stable(convChannel))
      else $error("channel changed while a request was open");
   regrst_quiet_a: assert property (regResetCmd |-> ##2 quiet8)
      else $error("conversion after register reset");
   wdog_quiet_a: assert property (watchdogExpiry |-> ##2 quiet8)
      else $error("conversion after watchdog expiry");
endmodule // adc_channel_select_and_results_assertions

bind adc_channel_select_and_results
   adc_channel_select_and_results_assertions chk_u (.clock(clock),
   .rst(rst), .ce(ce), .sclPin(sclPin), .sdaPin(sdaPin), .sdaOut(sdaOut),
   .sdaOe(sdaOe), .regResetCmd(regResetCmd),
   .watchdogExpiry(watchdogExpiry), .convStart(convStart),
   .convChannel(convChannel), .convDone(convDone), .convData(convData));
`default_nettype wire

// *** adc_channel_select_and_results_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_channel_select_and_results_tb;
   localparam logic [6:0] DEV = 7'h2a; // Arbitrary bus address
   logic clock, rst, ce, sclL, sdaH, regResetCmd, watchdogExpiry;
   logic slow, clr, sdaOut, sdaOe, convStart, convDone;
   logic [3:0] convChannel;
   logic [7:0] a, b;
   logic [15:0] convData, base, r;
   logic [10:0] seen;
   int n_mismatch = 0, samples_checked = 0, seed = 13314, k, j;
   wire logic sdaPin = sdaH & ~sdaOe;

   adc_channel_select_and_results #(.DEV_ADDR(DEV)) dut_u (
      .clock(clock), .rst(rst), .ce(ce), .sclPin(sclL), .sdaPin(sdaPin),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .regResetCmd(regResetCmd),
      .watchdogExpiry(watchdogExpiry), .convStart(convStart),
      .convChannel(convChannel), .convDone(convDone), .convData(convData));
   conv_model conv_u (.clock(clock), .clr(clr), .convStart(convStart),
      .convChannel(convChannel), .base(base), .slow(slow),
      .convDone(convDone), .convData(convData), .seen(seen));

   // Clock
   initial begin
      clock = 1'h0;
      forever #20 clock = ~clock;
   end

   // *****
   // Helpers
   // *****
   function automatic logic [15:0] resWord(input logic [3:0] ch);
      return base + {12'h000, ch};
   endfunction
   task automatic w(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic chk(input string what, input logic [15:0] e,
                      input logic [15:0] s);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, e, s);
      end
   endtask
   task automatic bitOut(input logic v);
      sdaH <= v;
      w(4);
      sclL <= 1'h1;
      w(8);
      sclL <= 1'h0;
      w(4);
   endtask
   task automatic bitIn(output logic v);
      sdaH <= 1'h1;
      w(4);
      sclL <= 1'h1;
      w(4);
      @(negedge clock) v = sdaPin;
      w(4);
      sclL <= 1'h0;
      w(4);
   endtask
   task automatic start();
      sdaH <= 1'h1;
      w(4);
      sclL <= 1'h1;
      w(8);
      sdaH <= 1'h0;
      w(8);
      sclL <= 1'h0;
      w(4);
   endtask
   task automatic stop();
      sdaH <= 1'h0;
      w(4);
      sclL <= 1'h1;
      w(8);
      sdaH <= 1'h1;
      w(8);
   endtask
   task automatic tx(input logic [7:0] d, input logic nack);
      logic ack;
      for (int i = 7; i >= 0; i--) bitOut(d[i]);
      bitIn(ack);
      chk("ack", {15'h0000, nack}, {15'h0000, ack});
   endtask
   task automatic rx(output logic [7:0] d, input logic last);
      for (int i = 7; i >= 0; i--) bitIn(d[i]);
      bitOut(last);
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      start();
      tx({DEV, 1'h0}, 1'h0);
      tx(ad, 1'h0);
      tx(d, 1'h0);
      stop();
   endtask
   task automatic rd(input logic [7:0] ad, output logic [15:0] v);
      start();
      tx({DEV, 1'h0}, 1'h0);
      tx(ad, 1'h0);
      start();
      tx({DEV, 1'h1}, 1'h0);
      rx(v[15:8], 1'h0);
      rx(v[7:0], 1'h1);
      stop();
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Watchdog against a hung run
   initial begin
      w(90000);
      n_mismatch++;
      end_of_test();
   end

   // *****
   // Tests
   // *****
   initial begin
      rst = 1'h1; ce = 1'h1; sclL = 1'h1; sdaH = 1'h1; clr = 1'h0;
      regResetCmd = 1'h0; watchdogExpiry = 1'h0; slow = 1'h0;
      base = 16'h0000;
      w(6);
      rst <= 1'h0;
      w(1);
      // Power-on values
      rd(adc_regs_pkg::ADDR_DIS_PRI, r);
      chk("disables", 16'h0000, r);
      rd(adc_regs_pkg::ADDR_CTRL, r);
      chk("control", 16'h3000, r);
      for (k = 0; k < 4; k++) begin
         rd(adc_regs_pkg::ADDR_IBUS_HI + 8'(2 * k), r);
         chk("result", 16'h0000, r);
      end
      $display("end of reset test");
      // Disable bits with reserved positions, first pass all ones
      for (k = 0; k < 4; k++) begin
         a = (k == 0) ? 8'hff : 8'($random(seed));
         b = (k == 0) ? 8'hff : 8'($random(seed));
         wr(adc_regs_pkg::ADDR_DIS_PRI, a);
         wr(adc_regs_pkg::ADDR_DIS_SEC, b);
         rd(adc_regs_pkg::ADDR_DIS_PRI, r);
         chk("disables", {a & 8'hfe, b & 8'hf0}, r);
      end
      regResetCmd <= 1'h1;
      w(1);
      regResetCmd <= 1'h0;
      w(1);
      rd(adc_regs_pkg::ADDR_DIS_PRI, r);
      chk("disables", 16'h0000, r);
      $display("end of disable test");
      // Refused accesses
      wr(adc_regs_pkg::ADDR_IBUS_HI, 8'ha5);
      rd(adc_regs_pkg::ADDR_IBUS_HI, r);
      chk("result", 16'h0000, r);
      rd(8'h50, r);
      chk("unmapped", 16'h0000, r);
      start();
      tx({~DEV, 1'h0}, 1'h1);
      stop();
      $display("end of refusal test");
      // One-shot passes over channels 0, 1, 2 and 10
      for (k = 0; k < 3; k++) begin
         base <= (k == 0) ? 16'h8000 : 16'($random(seed));
         slow <= k[0];
         clr <= 1'h1;
         w(1);
         clr <= 1'h0;
         wr(adc_regs_pkg::ADDR_DIS_PRI, 8'h1e);
         wr(adc_regs_pkg::ADDR_DIS_SEC, 8'he0);
         wr(adc_regs_pkg::ADDR_CTRL, 8'hc0);
         r = 16'hffff;
         for (j = 0; j < 20 && r[15]; j++) rd(adc_regs_pkg::ADDR_CTRL, r);
         chk("control", 16'h401e, r);
         chk("channels", 16'h0407, {5'h00, seen});
         for (j = 0; j < 4; j++) begin
            rd(adc_regs_pkg::ADDR_IBUS_HI + 8'(2 * j), r);
            b = (j == 3) ? 8'h0a : 8'(j);
            chk("result", resWord(b[3:0]), r);
         end
         clr <= 1'h1;
         w(1);
         clr <= 1'h0;
         w(100);
         chk("channels", 16'h0000, {5'h00, seen});
         $display("end of scan pass %0d", k);
      end
      // Continuous scan stopped by watchdog expiry
      wr(adc_regs_pkg::ADDR_CTRL, 8'h80);
      w(200);
      chk("channels", 16'h0407, {5'h00, seen});
      watchdogExpiry <= 1'h1;
      w(1);
      watchdogExpiry <= 1'h0;
      w(30);
      clr <= 1'h1;
      w(1);
      clr <= 1'h0;
      w(200);
      chk("channels", 16'h0000, {5'h00, seen});
      rd(adc_regs_pkg::ADDR_CTRL, r);
      chk("control", 16'h001e, r);
      $display("end of watchdog test");
      end_of_test();
   end
endmodule // adc_channel_select_and_results_tb
`default_nettype wire

// *** adc_regs_pkg.sv ***
`default_nettype none
package adc_regs_pkg;

   // ********************************************************
   // Register offsets
   // ********************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h2e;
   localparam logic [7:0] ADDR_DIS_PRI = 8'h2f;
   localparam logic [7:0] ADDR_DIS_SEC = 8'h30;
   localparam logic [7:0] ADDR_IBUS_HI = 8'h31;
   localparam logic [7:0] ADDR_IBUS_LO = 8'h32;
   localparam logic [7:0] ADDR_IBAT_HI = 8'h33;
   localparam logic [7:0] ADDR_IBAT_LO = 8'h34;
   localparam logic [7:0] ADDR_VBUS_HI = 8'h35;
   localparam logic [7:0] ADDR_VBUS_LO = 8'h36;
   localparam logic [7:0] ADDR_VAC1_HI = 8'h37;
   localparam logic [7:0] ADDR_VAC1_LO = 8'h38;

   // ********************************************************
   // Reset values and field layout
   // ********************************************************
   localparam logic [7:0] CTRL_RESET = 8'h30;
   localparam logic [7:0] DIS_RESET = 8'h00;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam logic [2:0] CTRL_EN_BIT = 3'h7;
   localparam logic [2:0] CTRL_RATE_BIT = 3'h6;
   localparam logic [7:0] CTRL_WMASK = 8'hfc;
   localparam logic [7:0] DIS_PRI_WMASK = 8'hfe;
   localparam logic [7:0] DIS_SEC_WMASK = 8'hf0;

   // ********************************************************
   // Serial bus framing
   // ********************************************************
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   localparam logic [3:0] BIT_ONE = 4'h1;
   localparam logic [7:0] PTR_STEP = 8'h01;

   // ********************************************************
   // Scan channels, in conversion order
   // ********************************************************
   localparam int NUM_CH = 11;
   typedef enum logic [3:0] {
      CH_IBUS = 4'h0,
      CH_IBAT = 4'h1,
      CH_VBUS = 4'h2,
      CH_VBAT = 4'h3,
      CH_VSYS = 4'h4,
      CH_TS = 4'h5,
      CH_TDIE = 4'h6,
      CH_DP = 4'h7,
      CH_DM = 4'h8,
      CH_VAC2 = 4'h9,
      CH_VAC1 = 4'ha
   } chan_e;
   localparam logic [3:0] CH_STEP = 4'h1;

endpackage
`default_nettype wire

// *** adc_scan_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_scan_seq (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   scan_if.seq scan,
   output logic convStart,
   output logic [3:0] convChannel,
   input wire logic convDone,
   input wire logic [15:0] convData
);
   typedef enum logic [1:0] {
      SCAN_IDLE = 2'h0,
      SCAN_PICK = 2'h1,
      SCAN_WAIT = 2'h2
   } scan_e;

   scan_e state, next_state;
   logic [3:0] next_convChannel;
   logic next_convStart;
   logic next_resultValid;
   logic [15:0] next_resultWord;
   logic next_passDone;

   // Walk enabled channels; one-shot stops after last channel
   always_comb begin
      next_state = state;
      next_convChannel = convChannel;
      next_convStart = 1'b0;
      next_resultValid = 1'b0;
      next_resultWord = scan.resultWord;
      next_passDone = 1'b0;
      if (!scan.enable) begin
         next_state = SCAN_IDLE;
      end else begin
         case (state)
            SCAN_IDLE: begin
               next_convChannel = adc_regs_pkg::CH_IBUS;
               next_state = SCAN_PICK;
            end
            SCAN_PICK: begin
               if (convChannel > adc_regs_pkg::CH_VAC1) begin
                  next_passDone = 1'b1;
                  next_convChannel = adc_regs_pkg::CH_IBUS;
                  if (scan.oneShot) begin
                     next_state = SCAN_IDLE;
                  end
               end else if (scan.offMask[convChannel]) begin
                  next_convChannel = convChannel + adc_regs_pkg::CH_STEP;
               end else begin
                  next_convStart = 1'b1;
                  next_state = SCAN_WAIT;
               end
            end
            SCAN_WAIT: begin
               if (convDone) begin
                  next_resultValid = 1'b1;
                  next_resultWord = convData;
                  next_convChannel = convChannel + adc_regs_pkg::CH_STEP;
                  next_state = SCAN_PICK;
               end
            end
            default: begin
               next_state = SCAN_IDLE;
            end
         endcase
      end
   end

   // State registers
   always_ff @(posedge clock) begin
      if (rst) begin
         state <= SCAN_IDLE;
         convChannel <= adc_regs_pkg::CH_IBUS;
         convStart <= 1'b0;
         scan.resultValid <= 1'b0;
         scan.resultWord <= adc_regs_pkg::RESULT_RESET;
         scan.passDone <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         convChannel <= next_convChannel;
         convStart <= next_convStart;
         scan.resultValid <= next_resultValid;
         scan.resultWord <= next_resultWord;
         scan.passDone <= next_passDone;
      end
   end

   // Channel of the word just stored; the counter has already stepped on
   assign scan.resultChan = convChannel - adc_regs_pkg::CH_STEP;
endmodule // adc_scan_seq
`default_nettype wire

// *** conv_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module conv_model (
   input wire logic clock,
   input wire logic clr,
   input wire logic convStart,
   input wire logic [3:0] convChannel,
   input wire logic [15:0] base,
   input wire logic slow,
   output logic convDone,
   output logic [15:0] convData,
   output logic [10:0] seen
);
   logic [15:0] held;

   // Answer each request after a short or a long delay
   initial begin
      convDone = 1'h0;
      convData = 16'h0000;
      forever begin
         @(posedge clock);
         if (convStart === 1'h1) begin
            held = base + {12'h000, convChannel};
            repeat (slow ? 20 : 1 + convChannel[1:0]) @(posedge clock);
            convData <= held;
            convDone <= 1'h1;
            @(posedge clock);
            convDone <= 1'h0;
            convData <= ~held; // Stale word is not kept
         end
      end
   end

   // Record which channels were requested
   always @(posedge clock) begin
      if (clr) seen <= 11'h000;
      else if (convStart === 1'h1) seen[convChannel] <= 1'h1;
   end
endmodule // conv_model
`default_nettype wire

// *** pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   // Two stages; first stage feeds only the second
   always_comb begin
      next_meta = ce ? d : meta;
      next_q = ce ? meta : q;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         meta <= '1;
         q <= '1;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule // pin_sync
`default_nettype wire

// *** scan_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface scan_if;
   logic enable;
   logic oneShot;
   logic [adc_regs_pkg::NUM_CH-1:0] offMask;
   logic resultValid;
   logic [3:0] resultChan;
   logic [15:0] resultWord;
   logic passDone;

   modport seq (
      input enable,
      input oneShot,
      input offMask,
      output resultValid,
      output resultChan,
      output resultWord,
      output passDone
   );
   modport regs (
      output enable,
      output oneShot,
      output offMask,
      input resultValid,
      input resultChan,
      input resultWord,
      input passDone
   );
endinterface
`default_nettype wire
